// File: spx_aux_chk_assertions.sv
// Purpose: port checks for spx_aux_regs
// Assumes: a write is taken 5 edges after both resets lift
// Notes: event flags are judged by the bench
`timescale 1ns/1ns
module spx_aux_chk (
	input wire       MCLK_I,
	input wire       ARST_N_I,
	input wire       COMP_RST_N_I,
	input wire [7:0] IO_ADDR_I,
	input wire       IO_WR_I,
	input wire       IO_RD_I,
	input wire [7:0] IO_WDATA_I,
	input wire [7:0] IO_RDATA_O,
	input wire [1:0] TERM_READY_O,
	input wire [3:0] TX_DMA_EN_O,
	input wire       IRQ_O
);
	// one clock domain, async reset
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!ARST_N_I);
	// a write the block will take
	sequence wr_to(a);
		(ARST_N_I && COMP_RST_N_I)[*5] ##0 IO_WR_I && IO_ADDR_I == a;
	endsequence
	chk_ready_a: assert property (wr_to(8'h20) |=>
		TERM_READY_O[0] == $past(IO_WDATA_I[0])) else $error("rdy a");
	chk_dma_a: assert property (wr_to(8'h20) |=>
		{TX_DMA_EN_O[2],TX_DMA_EN_O[0]} == $past(IO_WDATA_I[2:1]))
		else $error("dma a");
	chk_chan_b: assert property (wr_to(8'h40) |=>
		{TX_DMA_EN_O[3],TX_DMA_EN_O[1],TERM_READY_O[1]} ==
		$past(IO_WDATA_I[2:0])) else $error("chan b");
	chk_comp_rst: assert property ((!COMP_RST_N_I)[*4] |->
		TERM_READY_O == 2'h0 && TX_DMA_EN_O == 4'h0 && !IRQ_O)
		else $error("comp rst");
	chk_spare_bits: assert property (IO_RD_I |=> IO_RDATA_O[7:5] == 3'h0)
		else $error("spare");
	chk_idle_read: assert property (!IO_RD_I |=> IO_RDATA_O == 8'h00)
		else $error("idle");
	chk_unmapped_read: assert property (IO_RD_I &&
		IO_ADDR_I != 8'h20 &&
		IO_ADDR_I != 8'h40 |=> IO_RDATA_O == 8'h00) else $error("unmap");
	chk_read_back: assert property (IO_RD_I && !IO_WR_I &&
		IO_ADDR_I == 8'h20 |=> IO_RDATA_O[0] == $past(TERM_READY_O[0]))
		else $error("rdbk");
endmodule // spx_aux_chk

// File: spx_aux_regs.v
// Purpose: two auxiliary control/status registers for the serial ports
// Assumes: single 10 MHz clock, modem and tc inputs asynchronous
// Notes:   one shared interrupt request, register reset from outside
//
// Summary of operation
// - two identical 8-bit registers, channels A and B
// - set-ready toggle either way records modem event
// - ring rising edge only records modem event
// - dma terminal count records tc event
// - read bits 0-2 show ready and ring levels
// - read bit 3 low means modem event
// - read bit 4 low means terminal count
// - interrupt when flag low and bit 5 set
// - write bit 0 drives terminal ready
// - chan A bits 1,2 enable dma 0,2
// - chan B bits 1,2 enable dma 1,3
// - writing 1 to bit 3 clears modem event
// - writing 1 to bit 4 clears tc event
// - write bit 5 gates channel interrupts
// - both channel requests ORed onto one line
// - component reset clears outputs, flags, enables
// - in reset reads bit0 0, bits 3,4 1
// - reset released when component bit goes 1
// - dma used for transmit only, 8-bit
`timescale 1ns/1ns
`include "spx_defs.vh"
module spx_aux_regs (
	input  wire        MCLK_I,
	input  wire        ARST_N_I,
	input  wire        COMP_RST_N_I,
	input  wire [7:0]  IO_ADDR_I,
	input  wire        IO_WR_I,
	input  wire        IO_RD_I,
	input  wire [7:0]  IO_WDATA_I,
	output reg  [7:0]  IO_RDATA_O,
	input  wire [1:0]  SET_READY_I,
	input  wire [1:0]  RING_I,
	input  wire [3:0]  DMA_TC_I,
	output wire [1:0]  TERM_READY_O,
	output wire [3:0]  TX_DMA_EN_O,
	output wire        IRQ_O
);

	// reset release through two flops
	reg        rst_s1_q;
	reg        rst_n_q;
	always @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// synchronise the component reset bit level
	reg        crst_s1_q;
	reg        crst_q;
	always @(posedge MCLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			crst_s1_q <= 1'b0;
			crst_q    <= 1'b0;
		end else begin
			crst_s1_q <= COMP_RST_N_I;
			crst_q    <= crst_s1_q;
		end
	end
	wire       reg_rst = ~crst_q;

	// register selects; writes refused while held in reset
	wire       sel_a = (IO_ADDR_I == `SPX_ADDR_CHAN_A);
	wire       sel_b = (IO_ADDR_I == `SPX_ADDR_CHAN_B);
	wire [1:0] wr_ch = {sel_b, sel_a} & {2{IO_WR_I & ~reg_rst}};

	// per-channel status words and requests
	wire [15:0] rd_flat;
	wire [1:0]  ch_irq;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
			// synchroniser and edge history flops
			reg  [1:0] sr_sync_q;
			reg  [1:0] ri_sync_q;
			reg  [1:0] tc_sync_q;
			reg        sr_last_q;
			reg        ri_last_q;
			reg        tc_last_q;
			// event flags and control bits
			reg        modem_q;
			reg        modem_d;
			reg        tc_q;
			reg        tc_d;
			reg        term_rdy_q;
			reg        term_rdy_d;
			reg        dma_lo_q;
			reg        dma_lo_d;
			reg        dma_hi_q;
			reg        dma_hi_d;
			reg        irq_en_q;
			reg        irq_en_d;
			// settled pin levels
			wire       sr_now = sr_sync_q[1];
			wire       ri_now = ri_sync_q[1];
			wire       tc_now = tc_sync_q[1];
			// either dma channel of this port may end a block
			wire       tc_pin = DMA_TC_I[ch] | DMA_TC_I[ch + 2];
			// events, seen only after the synchronisers
			wire       sr_ev = sr_now ^ sr_last_q;
			wire       ri_ev = ri_now & ~ri_last_q;
			wire       modem_ev = sr_ev | ri_ev;
			wire       tc_ev = tc_now & ~tc_last_q;
			// write-one clear strobes
			wire       wr_me = wr_ch[ch];
			wire       modem_clr = wr_me
				& IO_WDATA_I[`SPX_WR_MODEM_CLR];
			wire       tc_clr = wr_me
				& IO_WDATA_I[`SPX_WR_TC_CLR];

			// set-ready pin synchroniser
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					sr_sync_q <= 2'b00;
				end else begin
					sr_sync_q <= {sr_sync_q[0], SET_READY_I[ch]};
				end
			end

			// ring pin synchroniser
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					ri_sync_q <= 2'b00;
				end else begin
					ri_sync_q <= {ri_sync_q[0], RING_I[ch]};
				end
			end

			// terminal count synchroniser
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					tc_sync_q <= 2'b00;
				end else begin
					tc_sync_q <= {tc_sync_q[0], tc_pin};
				end
			end

			// set-ready history, idle low after reset
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					sr_last_q <= 1'b0;
				end else begin
					sr_last_q <= sr_now;
				end
			end

			// ring history, idle low after reset
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					ri_last_q <= 1'b0;
				end else begin
					ri_last_q <= ri_now;
				end
			end

			// terminal count history
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					tc_last_q <= 1'b0;
				end else begin
					tc_last_q <= tc_now;
				end
			end

			// modem flag next value; set beats clear
			always @* begin
				modem_d = modem_q;
				if (reg_rst) begin
					modem_d = `SPX_RST_FLAG;
				end else if (modem_ev) begin
					modem_d = 1'b1;
				end else if (modem_clr) begin
					modem_d = 1'b0;
				end
			end

			// tc flag next value; set beats clear
			always @* begin
				tc_d = tc_q;
				if (reg_rst) begin
					tc_d = `SPX_RST_FLAG;
				end else if (tc_ev) begin
					tc_d = 1'b1;
				end else if (tc_clr) begin
					tc_d = 1'b0;
				end
			end

			// control bits next value
			always @* begin
				term_rdy_d = term_rdy_q;
				dma_lo_d   = dma_lo_q;
				dma_hi_d   = dma_hi_q;
				irq_en_d   = irq_en_q;
				if (reg_rst) begin
					term_rdy_d = `SPX_RST_BIT;
					dma_lo_d   = `SPX_RST_BIT;
					dma_hi_d   = `SPX_RST_BIT;
					irq_en_d   = `SPX_RST_BIT;
				end else if (wr_me) begin
					term_rdy_d = IO_WDATA_I[`SPX_WR_TERM_RDY];
					dma_lo_d   = IO_WDATA_I[`SPX_WR_DMA_LO];
					dma_hi_d   = IO_WDATA_I[`SPX_WR_DMA_HI];
					irq_en_d   = IO_WDATA_I[`SPX_WR_IRQ_EN];
				end
			end

			// modem event flag
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					modem_q <= `SPX_RST_FLAG;
				end else begin
					modem_q <= modem_d;
				end
			end

			// terminal count flag
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					tc_q <= `SPX_RST_FLAG;
				end else begin
					tc_q <= tc_d;
				end
			end

			// terminal-ready control bit
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					term_rdy_q <= `SPX_RST_BIT;
				end else begin
					term_rdy_q <= term_rdy_d;
				end
			end

			// low dma channel enable
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					dma_lo_q <= `SPX_RST_BIT;
				end else begin
					dma_lo_q <= dma_lo_d;
				end
			end

			// high dma channel enable
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					dma_hi_q <= `SPX_RST_BIT;
				end else begin
					dma_hi_q <= dma_hi_d;
				end
			end

			// interrupt enable bit
			always @(posedge MCLK_I or negedge rst_n_q) begin
				if (!rst_n_q) begin
					irq_en_q <= `SPX_RST_BIT;
				end else begin
					irq_en_q <= irq_en_d;
				end
			end

			// status word: levels, active-low flags
			assign rd_flat[ch*8 +: 8] = {
				3'b000,      // spare bits read zero
				~tc_q,
				~modem_q,
				ri_now,
				sr_now,
				term_rdy_q
			};

			// request while a flag is up and enabled
			assign ch_irq[ch] = (modem_q | tc_q)
				& irq_en_q;
			// terminal-ready pin follows write bit 0
			assign TERM_READY_O[ch] = term_rdy_q;
			// transmit-only enables on 8-bit dma channels
			assign TX_DMA_EN_O[ch]     = dma_lo_q;
			assign TX_DMA_EN_O[ch + 2] = dma_hi_q;
		end
	endgenerate

	// one request line for both channels
	assign IRQ_O = |ch_irq;

	// read data register, address picks the channel
	always @(posedge MCLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			IO_RDATA_O <= 8'h00;
		end else if (IO_RD_I && sel_a) begin
			IO_RDATA_O <= rd_flat[7:0];
		end else if (IO_RD_I && sel_b) begin
			IO_RDATA_O <= rd_flat[15:8];
		end else begin
			IO_RDATA_O <= 8'h00;
		end
	end

endmodule // spx_aux_regs

// File: spx_aux_regs_bench.sv
// Purpose: self-checking bench for spx_aux_regs
// Assumes: event latency under 6 cycles
// Notes: outs packs {0, ready, dma, irq}
`timescale 1ns/1ns
module spx_aux_regs_bench;
	reg        clk = 1'b0, arst_n = 1'b0, comp_n = 1'b0, wr = 1'b0, rd = 1'b0;
	reg  [7:0] addr = 8'h00, wd = 8'h00, cmd = 8'h00;
	wire [7:0] rdat, ln;
	wire [1:0] tr;
	wire [3:0] dma;
	wire       irq;
	integer    err_count = 0, n_compared = 0, cyc = 0;
	// clock, and a ceiling on run length
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count = err_count + 1;
			end_of_test;
		end
	end
	spx_aux_regs DUT (.MCLK_I(clk), .ARST_N_I(arst_n), .COMP_RST_N_I(comp_n),
		.IO_ADDR_I(addr), .IO_WR_I(wr), .IO_RD_I(rd), .IO_WDATA_I(wd),
		.IO_RDATA_O(rdat), .SET_READY_I(ln[1:0]), .RING_I(ln[3:2]),
		.DMA_TC_I(ln[7:4]), .TERM_READY_O(tr), .TX_DMA_EN_O(dma), .IRQ_O(irq));
	spx_far_model far (.clk_i(clk), .cmd_i(cmd), .lines_o(ln));
	task check(input [7:0] seen, input [7:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("MISMATCH %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task outs(input [7:0] exp);
		check({1'b0, tr, dma, irq}, exp);
	endtask
	task wreg(input [7:0] a, input [7:0] d);
		@(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
		@(posedge clk) wr <= 1'b0;
		#1;
	endtask
	task rreg(input [7:0] a, input [7:0] exp);
		@(posedge clk) {rd, addr} <= {1'b1, a};
		@(posedge clk) rd <= 1'b0;
		#1 check(rdat, exp);
	endtask
	task line(input [7:0] c);
		@(posedge clk) cmd <= c;
		repeat (6) @(posedge clk);
		#1;
	endtask
	// writes ignored while held in reset
	task t_reset;
		wreg(8'h20, 8'h27);
		outs(8'h00);
		rreg(8'h20, 8'h18);
		$display("reset test done");
	endtask
	// control bits, dma gating, unmapped read
	task t_ctrl;
		wreg(8'h20, 8'h27);
		outs(8'h2a);
		wreg(8'h40, 8'h07);
		outs(8'h7e);
		wreg(8'h40, 8'h01);
		outs(8'h6a);
		rreg(8'h40, 8'h19);
		rreg(8'h60, 8'h00);
		$display("control test done");
	endtask
	// set-ready both ways, ring rise only
	task t_modem;
		line(8'h01);
		rreg(8'h20, 8'h13);
		outs(8'h6b);
		wreg(8'h20, 8'h2f);
		rreg(8'h20, 8'h1b);
		line(8'h00);
		wreg(8'h20, 8'h27);
		rreg(8'h20, 8'h11);
		wreg(8'h20, 8'h2f);
		line(8'h08);
		rreg(8'h40, 8'h15);
		outs(8'h6a);
		wreg(8'h40, 8'h09);
		line(8'h00);
		rreg(8'h40, 8'h19);
		$display("modem test done");
	endtask
	// tc pulse stays latched until cleared
	task t_tc;
		line(8'h80);
		line(8'h00);
		rreg(8'h40, 8'h09);
		wreg(8'h40, 8'h21);
		outs(8'h6b);
		wreg(8'h40, 8'h31);
		outs(8'h6a);
		$display("tc test done");
	endtask
	// channel A tc and ring, channel B set-ready
	task t_more;
		line(8'h10);
		line(8'h00);
		rreg(8'h20, 8'h09);
		outs(8'h6b);
		line(8'h04);
		rreg(8'h20, 8'h05);
		wreg(8'h20, 8'h39);
		line(8'h00);
		outs(8'h60);
		line(8'h02);
		outs(8'h61);
		$display("more test done");
	endtask
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		t_reset;
		@(posedge clk) comp_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_ctrl;
		t_modem;
		t_tc;
		t_more;
		end_of_test;
	end
endmodule // spx_aux_regs_bench
bind spx_aux_regs spx_aux_chk u_chk (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I),
	.COMP_RST_N_I(COMP_RST_N_I), .IO_ADDR_I(IO_ADDR_I), .IO_WR_I(IO_WR_I),
	.IO_RD_I(IO_RD_I), .IO_WDATA_I(IO_WDATA_I), .IO_RDATA_O(IO_RDATA_O),
	.TERM_READY_O(TERM_READY_O), .TX_DMA_EN_O(TX_DMA_EN_O), .IRQ_O(IRQ_O));

// File: spx_defs.vh
// Purpose: constants for the serial port auxiliary control registers
// Assumes: byte-wide i/o channel, whole 8-bit address selects the register
// Notes:   register selects are decoded from the i/o address
`ifndef SPX_DEFS_VH
`define SPX_DEFS_VH
// register addresses on the i/o channel
`define SPX_ADDR_W        8
`define SPX_ADDR_CHAN_A   8'h20
`define SPX_ADDR_CHAN_B   8'h40
// read field positions
`define SPX_RD_TERM_RDY   0
`define SPX_RD_SET_RDY    1
`define SPX_RD_RING       2
`define SPX_RD_MODEM_N    3
`define SPX_RD_TC_N       4
// write field positions
`define SPX_WR_TERM_RDY   0
`define SPX_WR_DMA_LO     1
`define SPX_WR_DMA_HI     2
`define SPX_WR_MODEM_CLR  3
`define SPX_WR_TC_CLR     4
`define SPX_WR_IRQ_EN     5
// reset values
`define SPX_RST_CTRL      6'h00
`define SPX_RST_FLAG      1'b0
`define SPX_RST_BIT       1'b0
`endif

// File: spx_far_model.sv
// Purpose: far side modem lines and dma terminal count
// Assumes: bench commands levels as {tc, ring, set_ready}
// Notes: lines move one edge after a command
`timescale 1ns/1ns
module spx_far_model (
	input  wire       clk_i,
	input  wire [7:0] cmd_i,
	output reg  [7:0] lines_o
);
	// lines start inactive, then follow commands
	initial lines_o = 8'h00;
	always @(posedge clk_i) lines_o <= cmd_i;
endmodule // spx_far_model
